/* File: lin_resync_defs.vh */
`ifndef LIN_RESYNC_DEFS_VH
`define LIN_RESYNC_DEFS_VH

// ----------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------
`define REG_STATUS        3'h0
`define REG_DATA          3'h1
`define REG_BAUD_FIRST    3'h2
`define REG_BAUD_SECOND   3'h3
`define REG_CONTROL       3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ST_HDR_ERR_BIT    0
`define ST_RX_FULL_BIT    1
`define ST_HDR_DONE_BIT   2
`define ST_FRAME_ERR_BIT  3
`define ST_MEASURING_BIT  4
`define CT_LINE_EN_BIT    0
`define CT_SLAVE_SEL_BIT  1
`define CT_RESYNC_EN_BIT  2
`define CT_DUM_BIT        3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define NOM_DIV_RST       16'h0010
`define CONTROL_RST       8'h00

// ----------------------------------------------------------------
// Protocol figures and timing counts
// ----------------------------------------------------------------
`define SYNCH_BYTE        8'h55
`define SYNCH_EDGES       3'h5
`define BREAK_BITS        20'h0000b
`define TIMEOUT_BITS      6'h39
`define OVERSAMPLE        5'h10
`define SAMPLE_A          4'h7
`define SAMPLE_C          4'h9
`define LAST_TICK         4'hf
`define STOP_BIT_IDX      4'h9
// Full-field limit 37/256 = 14.45 %, between 14.06 % and 14.84 %
`define DEV_FULL_NUM      28'h0000025
// Edge-to-edge limit 44/256 = 17.19 %, between 15.62 % and 18.75 %
`define DEV_EDGE_NUM      28'h000002c
`define DEV_SHIFT         8

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define MODE_OFF          2'h0
`define MODE_MASTER       2'h1
`define MODE_SLAVE        2'h2
`define MODE_RESYNC       2'h3

`endif

/* File: lin_slave_auto_baud_resync.v */
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "lin_resync_defs.vh"

module lin_slave_auto_baud_resync (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire       serial_receive_input,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_ff,
  output reg        header_error_flag_ff,
  output reg  [1:0] lin_mode_ff
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CHAR  = 3'h1;
  localparam [2:0] ST_BREAK = 3'h2;
  localparam [2:0] ST_DELIM = 3'h3;
  localparam [2:0] ST_MEAS  = 3'h4;
  localparam [2:0] ST_TAIL  = 3'h5;

  localparam [1:0] PH_NONE  = 2'h0;
  localparam [1:0] PH_SYNCH = 2'h1;
  localparam [1:0] PH_IDENT = 2'h2;

  function [1:0] mode_decode;
    input line_en;
    input slave_sel;
    input resync_en;
    begin
      if (!line_en)
        mode_decode = `MODE_OFF;
      else if (!slave_sel)
        mode_decode = `MODE_MASTER;
      else if (!resync_en)
        mode_decode = `MODE_SLAVE;
      else
        mode_decode = `MODE_RESYNC;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg        rx_meta_ff;
  reg        rx_sync_ff;
  reg        rx_prev_ff;
  reg        line_enable_ff;
  reg        slave_select_ff;
  reg        auto_resync_enable_ff;
  reg        divider_update_method_ff;
  reg [15:0] nominal_baud_divider_ff;
  reg [15:0] measured_baud_divider_ff;
  reg [15:0] active_baud_divider_ff;
  reg [7:0]  baud_second_hold_ff;
  reg [18:0] synch_measure_count_ff;
  reg        meas_ovf_ff;
  reg [2:0]  state_ff;
  reg [1:0]  hdr_ph_ff;
  reg [16:0] tick_cnt_ff;
  reg [3:0]  tick_idx_ff;
  reg [3:0]  bit_idx_ff;
  reg [1:0]  vote_ff;
  reg [7:0]  shift_ff;
  reg [19:0] low_cnt_ff;
  reg [2:0]  edge_cnt_ff;
  reg [16:0] iv_cnt_ff;
  reg [16:0] cyc_cnt_ff;
  reg        tmo_on_ff;
  reg [15:0] tmo_cyc_ff;
  reg [5:0]  tmo_bits_ff;
  reg        hdr_err_pulse_ff;
  reg        rx_load_pulse_ff;
  reg        fe_pulse_ff;
  reg        hdr_done_pulse_ff;
  reg        rx_not_empty_ff;
  reg        header_done_ff;
  reg        framing_err_ff;
  reg        status_read_ff;
  reg [7:0]  data_ff;

  wire [1:0]  mode = mode_decode(line_enable_ff, slave_select_ff, auto_resync_enable_ff);
  wire        lin_slave = mode[1];
  wire        fall = rx_prev_ff & ~rx_sync_ff;
  wire [15:0] div = active_baud_divider_ff;
  // Sixteen ticks spread over div cycles, so a bit lasts div cycles exactly when div is sixteen or more
  wire [16:0] tick_sum = tick_cnt_ff + {12'h000, `OVERSAMPLE};
  wire        tick = (tick_sum >= {1'b0, div});
  wire [16:0] tick_rem = tick_sum - {1'b0, div};
  // Dividers below sixteen tick every cycle, remainder dropped once it reaches div
  wire [16:0] nxt_tick_cnt = !tick ? tick_sum :
                             (tick_rem >= {1'b0, div}) ? 17'h00000 : tick_rem;
  wire [19:0] break_len = {4'h0, div} * `BREAK_BITS;
  wire        brk = lin_slave && (low_cnt_ff == break_len);
  wire [1:0]  vote_now = vote_ff + {1'b0, rx_sync_ff};
  wire        bit_val = (vote_now >= 2'h2);
  wire        wr_first = reg_wr && (reg_addr == `REG_BAUD_FIRST);
  wire [15:0] wr_nominal = {reg_wdata, baud_second_hold_ff};

  // Measured divider and deviation against the active divider
  wire [18:0] meas_end = synch_measure_count_ff + 19'h00001;
  wire [19:0] meas_round = ({1'b0, meas_end} + 20'h00004) >> 3;
  wire        meas_too_big = (meas_round[19:16] != 4'h0) || meas_ovf_ff;
  wire [27:0] nom8 = {9'h000, div, 3'h0};
  wire [27:0] meas28 = {9'h000, meas_end};
  wire [27:0] diff_full = (meas28 > nom8) ? meas28 - nom8 : nom8 - meas28;
  wire        dev_full = ((diff_full << `DEV_SHIFT) > (nom8 * `DEV_FULL_NUM));
  wire [27:0] nom2 = {11'h000, div, 1'b0};
  wire [27:0] iv28 = {11'h000, iv_cnt_ff} + 28'h0000001;
  wire        dev_edge = (iv28 < nom2) &&
                         (((nom2 - iv28) << `DEV_SHIFT) > (nom2 * `DEV_EDGE_NUM));
  wire [16:0] tail_len = {1'b0, div} + {2'h0, div[15:1]};

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_receive_input;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  // ----------------------------------------------------------------
  // Receive, break, synch measurement and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      state_ff                 <= ST_IDLE;
      hdr_ph_ff                <= PH_NONE;
      tick_cnt_ff              <= 17'h00000;
      tick_idx_ff              <= 4'h0;
      bit_idx_ff               <= 4'h0;
      vote_ff                  <= 2'h0;
      shift_ff                 <= 8'h00;
      low_cnt_ff               <= 20'h00000;
      edge_cnt_ff              <= 3'h0;
      iv_cnt_ff                <= 17'h00000;
      cyc_cnt_ff               <= 17'h00000;
      synch_measure_count_ff   <= 19'h00000;
      meas_ovf_ff              <= 1'b0;
      measured_baud_divider_ff <= 16'h0000;
      active_baud_divider_ff   <= `NOM_DIV_RST;
      nominal_baud_divider_ff  <= `NOM_DIV_RST;
      baud_second_hold_ff      <= 8'h00;
      line_enable_ff           <= 1'b0;
      slave_select_ff          <= 1'b0;
      auto_resync_enable_ff    <= 1'b0;
      divider_update_method_ff <= 1'b0;
      tmo_on_ff                <= 1'b0;
      tmo_cyc_ff               <= 16'h0000;
      tmo_bits_ff              <= 6'h00;
      hdr_err_pulse_ff         <= 1'b0;
      rx_load_pulse_ff         <= 1'b0;
      fe_pulse_ff              <= 1'b0;
      hdr_done_pulse_ff        <= 1'b0;
      data_ff                  <= 8'h00;
    end else begin
      hdr_err_pulse_ff  <= 1'b0;
      rx_load_pulse_ff  <= 1'b0;
      fe_pulse_ff       <= 1'b0;
      hdr_done_pulse_ff <= 1'b0;
      low_cnt_ff <= rx_sync_ff ? 20'h00000 :
                    (low_cnt_ff == 20'hfffff) ? low_cnt_ff : low_cnt_ff + 20'h00001;
      tick_cnt_ff <= nxt_tick_cnt;

      // Header timeout in bit times from break detection
      if (tmo_on_ff) begin
        if (tmo_cyc_ff >= div - 16'h0001) begin
          tmo_cyc_ff  <= 16'h0000;
          tmo_bits_ff <= tmo_bits_ff + 6'h01;
        end else begin
          tmo_cyc_ff <= tmo_cyc_ff + 16'h0001;
        end
      end

      if (brk) begin
        state_ff                 <= ST_BREAK;
        hdr_ph_ff                <= PH_NONE;
        divider_update_method_ff <= 1'b0;
        tmo_on_ff                <= 1'b1;
        tmo_cyc_ff               <= 16'h0000;
        tmo_bits_ff              <= 6'h00;
      end else if (tmo_on_ff && tmo_bits_ff == `TIMEOUT_BITS) begin
        hdr_err_pulse_ff <= 1'b1;
        tmo_on_ff        <= 1'b0;
        hdr_ph_ff        <= PH_NONE;
        state_ff         <= ST_IDLE;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (fall) begin
              state_ff    <= ST_CHAR;
              tick_cnt_ff <= 17'h00000;
              tick_idx_ff <= 4'h0;
              bit_idx_ff  <= 4'h0;
              vote_ff     <= 2'h0;
            end
          end
          ST_CHAR: begin
            if (tick) begin
              tick_idx_ff <= tick_idx_ff + 4'h1;
              if (tick_idx_ff >= `SAMPLE_A && tick_idx_ff < `SAMPLE_C)
                vote_ff <= vote_now;
              if (tick_idx_ff == `SAMPLE_C) begin
                if (bit_idx_ff == 4'h0 && bit_val) begin
                  state_ff <= ST_IDLE;
                end else if (bit_idx_ff == `STOP_BIT_IDX) begin
                  state_ff <= ST_IDLE;
                  if (hdr_ph_ff == PH_SYNCH) begin
                    if (!bit_val || shift_ff != `SYNCH_BYTE) begin
                      hdr_err_pulse_ff <= 1'b1;
                      hdr_ph_ff        <= PH_NONE;
                      tmo_on_ff        <= 1'b0;
                    end else begin
                      hdr_ph_ff <= PH_IDENT;
                    end
                  end else if (hdr_ph_ff == PH_IDENT) begin
                    hdr_ph_ff <= PH_NONE;
                    tmo_on_ff <= 1'b0;
                    if (!bit_val) begin
                      hdr_err_pulse_ff <= 1'b1;
                    end else begin
                      hdr_done_pulse_ff <= 1'b1;
                      rx_load_pulse_ff  <= 1'b1;
                      data_ff           <= shift_ff;
                    end
                  end else begin
                    rx_load_pulse_ff <= 1'b1;
                    fe_pulse_ff      <= ~bit_val;
                    data_ff          <= shift_ff;
                    if (divider_update_method_ff) begin
                      active_baud_divider_ff   <= nominal_baud_divider_ff;
                      divider_update_method_ff <= 1'b0;
                    end
                  end
                end else if (bit_idx_ff != 4'h0) begin
                  shift_ff <= {bit_val, shift_ff[7:1]};
                end
              end
              if (tick_idx_ff == `LAST_TICK) begin
                bit_idx_ff <= bit_idx_ff + 4'h1;
                vote_ff    <= 2'h0;
              end
            end
          end
          ST_BREAK: begin
            if (rx_sync_ff) begin
              // First high cycle already counts toward the delimiter
              state_ff   <= ST_DELIM;
              cyc_cnt_ff <= 17'h00001;
            end
          end
          ST_DELIM: begin
            cyc_cnt_ff <= cyc_cnt_ff + 17'h00001;
            if (fall) begin
              if (cyc_cnt_ff < {1'b0, div}) begin
                hdr_err_pulse_ff <= 1'b1;
                tmo_on_ff        <= 1'b0;
                state_ff         <= ST_IDLE;
              end else if (mode == `MODE_RESYNC) begin
                state_ff               <= ST_MEAS;
                hdr_ph_ff              <= PH_SYNCH;
                synch_measure_count_ff <= 19'h00000;
                meas_ovf_ff            <= 1'b0;
                iv_cnt_ff              <= 17'h00000;
                edge_cnt_ff            <= 3'h1;
              end else begin
                state_ff    <= ST_CHAR;
                hdr_ph_ff   <= PH_SYNCH;
                tick_cnt_ff <= 17'h00000;
                tick_idx_ff <= 4'h0;
                bit_idx_ff  <= 4'h0;
                vote_ff     <= 2'h0;
              end
            end
          end
          ST_MEAS: begin
            // Character receiver idle here, nothing reaches the data register
            divider_update_method_ff <= 1'b0;
            if (synch_measure_count_ff == 19'h7ffff)
              meas_ovf_ff <= 1'b1;
            else
              synch_measure_count_ff <= synch_measure_count_ff + 19'h00001;
            iv_cnt_ff <= (iv_cnt_ff == 17'h1ffff) ? iv_cnt_ff : iv_cnt_ff + 17'h00001;
            if (fall) begin
              iv_cnt_ff   <= 17'h00000;
              edge_cnt_ff <= edge_cnt_ff + 3'h1;
              if (dev_edge) begin
                hdr_err_pulse_ff <= 1'b1;
                hdr_ph_ff        <= PH_NONE;
                tmo_on_ff        <= 1'b0;
                state_ff         <= ST_IDLE;
              end else if (edge_cnt_ff == `SYNCH_EDGES - 3'h1) begin
                measured_baud_divider_ff <= meas_round[15:0];
                if (dev_full || meas_too_big) begin
                  hdr_err_pulse_ff <= 1'b1;
                  hdr_ph_ff        <= PH_NONE;
                  tmo_on_ff        <= 1'b0;
                  state_ff         <= ST_IDLE;
                end else begin
                  active_baud_divider_ff <= meas_round[15:0];
                  state_ff               <= ST_TAIL;
                  cyc_cnt_ff             <= 17'h00000;
                end
              end
            end
          end
          ST_TAIL: begin
            cyc_cnt_ff <= cyc_cnt_ff + 17'h00001;
            if (cyc_cnt_ff >= tail_len) begin
              state_ff <= ST_IDLE;
              if (rx_sync_ff) begin
                hdr_ph_ff <= PH_IDENT;
              end else begin
                hdr_err_pulse_ff <= 1'b1;
                hdr_ph_ff        <= PH_NONE;
                tmo_on_ff        <= 1'b0;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end

      // Register writes come last so a first-baud write overrides
      if (reg_wr) begin
        case (reg_addr)
          `REG_BAUD_SECOND: begin
            baud_second_hold_ff <= reg_wdata;
          end
          `REG_BAUD_FIRST: begin
            nominal_baud_divider_ff <= wr_nominal;
          end
          `REG_CONTROL: begin
            line_enable_ff           <= reg_wdata[`CT_LINE_EN_BIT];
            slave_select_ff          <= reg_wdata[`CT_SLAVE_SEL_BIT];
            auto_resync_enable_ff    <= reg_wdata[`CT_RESYNC_EN_BIT];
            divider_update_method_ff <= reg_wdata[`CT_DUM_BIT];
          end
          default: begin
          end
        endcase
      end
      if (wr_first)
        active_baud_divider_ff <= wr_nominal;
      if (wr_first)
        active_baud_divider_ff <= wr_nominal;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and read port
  // ----------------------------------------------------------------
  wire data_rd   = reg_rd && (reg_addr == `REG_DATA);
  wire seq_clear = data_rd && status_read_ff;

  always @(posedge ref_clk) begin
    if (reset) begin
      header_error_flag_ff <= 1'b0;
      rx_not_empty_ff      <= 1'b0;
      header_done_ff       <= 1'b0;
      framing_err_ff       <= 1'b0;
      status_read_ff       <= 1'b0;
      reg_rdata_ff         <= 8'h00;
      lin_mode_ff          <= `MODE_OFF;
    end else begin
      lin_mode_ff          <= mode;
      header_error_flag_ff <= hdr_err_pulse_ff | (header_error_flag_ff & ~seq_clear);
      framing_err_ff       <= fe_pulse_ff | (framing_err_ff & ~seq_clear);
      header_done_ff       <= hdr_done_pulse_ff | (header_done_ff & ~seq_clear);
      rx_not_empty_ff      <= rx_load_pulse_ff | (rx_not_empty_ff & ~data_rd);
      if (reg_rd && reg_addr == `REG_STATUS)
        status_read_ff <= 1'b1;
      else if (data_rd)
        status_read_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `REG_STATUS: begin
            reg_rdata_ff <= {3'h0, (state_ff == ST_MEAS), framing_err_ff, header_done_ff,
                             rx_not_empty_ff, header_error_flag_ff};
          end
          `REG_DATA: begin
            reg_rdata_ff <= data_ff;
          end
          `REG_BAUD_FIRST: begin
            reg_rdata_ff <= active_baud_divider_ff[15:8];
          end
          `REG_BAUD_SECOND: begin
            reg_rdata_ff <= active_baud_divider_ff[7:0];
          end
          `REG_CONTROL: begin
            reg_rdata_ff <= {4'h0, divider_update_method_ff, auto_resync_enable_ff,
                             slave_select_ff, line_enable_ff};
          end
          default: begin
            reg_rdata_ff <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule

/* File: lin_master_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Master node driving the receive line, idle high
// ----------------------------------------------------------------
module lin_master_model (
  input  wire  ref_clk,
  output logic rx_line
);
  initial rx_line = 1'b1;

  task automatic hold(input logic v, input int n);
    rx_line <= v;
    repeat (n) @(posedge ref_clk);
  endtask

  // Start, eight bits low first, stop
  task automatic send_char(input logic [7:0] b, input int bp);
    hold(1'b0, bp);
    for (int i = 0; i < 8; i++) hold(b[i], bp);
    hold(1'b1, bp);
  endtask

  // Thirteen low bits, then delimiter of dl cycles
  task automatic send_break(input int bp, input int dl);
    hold(1'b0, 13 * bp);
    hold(1'b1, dl);
  endtask

  task automatic send_header(input int bp, input int dl, input logic [7:0] sy, input logic [7:0] id);
    send_break(bp, dl);
    send_char(sy, bp);
    send_char(id, bp);
    hold(1'b1, 2 * bp);
  endtask
endmodule

/* File: lin_resync_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module lin_resync_asserts (
  input wire       ref_clk,
  input wire       reset,
  input wire       serial_receive_input,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata_ff,
  input wire       header_error_flag_ff,
  input wire [1:0] lin_mode_ff
);
  logic [7:0] ctrl_ff;
  logic [1:0] mode_exp;
  wire        rd_data = reg_rd && reg_addr == 3'h1;

  always @(posedge ref_clk) begin
    if (reset) ctrl_ff <= 8'h00;
    else if (reg_wr && reg_addr == 3'h4) ctrl_ff <= reg_wdata;
  end
  assign mode_exp = !ctrl_ff[0] ? 2'h0 : !ctrl_ff[1] ? 2'h1 : ctrl_ff[2] ? 2'h3 : 2'h2;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_nom_write;
    reg_wr && reg_addr == 3'h3 ##1 reg_wr && reg_addr == 3'h2;
  endsequence
  sequence s_read_back;
    reg_rd && reg_addr == 3'h2 ##1 reg_rd && reg_addr == 3'h3;
  endsequence

  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata_ff == 8'h00)
    else $error("unmapped index read not zero");
  a_control_read_back: assert property (reg_rd && reg_addr == 3'h4 |=>
    reg_rdata_ff[2:0] == ctrl_ff[2:0] && reg_rdata_ff[7:4] == 4'h0)
    else $error("control readback wrong");
  a_mode_decode: assert property (ctrl_ff == $past(ctrl_ff) && ctrl_ff == $past(ctrl_ff, 2)
    |-> lin_mode_ff == mode_exp)
    else $error("mode decode wrong");
  a_mode_needs_write: assert property ($changed(lin_mode_ff) |-> ctrl_ff != $past(ctrl_ff, 2))
    else $error("mode changed without control write");
  a_nominal_hi_back: assert property (s_nom_write ##1 reg_rd && reg_addr == 3'h2
    |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("active high byte not reloaded");
  a_nominal_lo_back: assert property (s_nom_write ##1 s_read_back
    |=> reg_rdata_ff == $past(reg_wdata, 4))
    else $error("active low byte not reloaded");
  a_error_holds: assert property (header_error_flag_ff && !rd_data && !$past(rd_data)
    |=> header_error_flag_ff)
    else $error("header error cleared without data read");
  a_error_needs_slave: assert property ($rose(header_error_flag_ff) |-> lin_mode_ff[1])
    else $error("header error outside slave modes");
  a_error_clear_read: assert property ($fell(header_error_flag_ff)
    |-> $past(rd_data) || $past(rd_data, 2))
    else $error("header error fell without data read");
endmodule

bind lin_slave_auto_baud_resync lin_resync_asserts u_chk (
  .ref_clk, .reset, .serial_receive_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_ff, .header_error_flag_ff, .lin_mode_ff
);

/* File: lin_slave_auto_baud_resync_bench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register-level bench with master node model
// ----------------------------------------------------------------
module lin_slave_auto_baud_resync_bench;
  logic       ref_clk;
  logic       reset;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] v;
  wire        rx_line;
  wire  [7:0] reg_rdata_ff;
  wire        header_error_flag_ff;
  wire  [1:0] lin_mode_ff;
  int         n_mismatch = 0;
  int         num_checks = 0;

  lin_master_model m (.ref_clk(ref_clk), .rx_line(rx_line));

  lin_slave_auto_baud_resync dut (
    .ref_clk(ref_clk), .reset(reset), .serial_receive_input(rx_line),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .header_error_flag_ff(header_error_flag_ff),
    .lin_mode_ff(lin_mode_ff)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata_ff;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic fchk(input logic exp);
    @(negedge ref_clk);
    chk({7'h00, header_error_flag_ff}, {7'h00, exp});
    @(posedge ref_clk);
  endtask

  // Status read then data read
  task automatic clr;
    rd(3'h0, v);
    rd(3'h1, v);
  endtask

  // Second then first, read both back with no gaps
  task automatic reload(input logic [7:0] hi, input logic [7:0] lo);
    reg_wr <= 1'b1;
    reg_addr <= 3'h3;
    reg_wdata <= lo;
    @(posedge ref_clk);
    reg_addr <= 3'h2;
    reg_wdata <= hi;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_addr <= 3'h3;
    @(negedge ref_clk);
    chk(reg_rdata_ff, hi);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata_ff, lo);
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rchk(3'h2, 8'h00);
    rchk(3'h3, 8'h10);
    rchk(3'h4, 8'h00);
    for (int a = 5; a < 8; a++) rchk(a[2:0], 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(3'h4, c[7:0]);
      repeat (2) @(negedge ref_clk);
      chk({6'h00, lin_mode_ff}, !c[0] ? 8'h00 : !c[1] ? 8'h01 : c[2] ? 8'h03 : 8'h02);
      @(posedge ref_clk);
    end
    $display("test reset and modes done");
    wr(3'h4, 8'h07);
    m.send_header(17, 17, 8'h55, 8'h3c);
    fchk(1'b0);
    rchk(3'h3, 8'h11);
    rchk(3'h2, 8'h00);
    rchk(3'h0, 8'h0e);
    rchk(3'h1, 8'h3c);
    m.send_header(19, 19, 8'h55, 8'h3c);
    fchk(1'b0);
    rchk(3'h3, 8'h13);
    reload(8'h00, 8'h10);
    m.send_header(20, 20, 8'h55, 8'h3c);
    fchk(1'b1);
    rchk(3'h3, 8'h10);
    rd(3'h1, v);
    fchk(1'b1);
    clr;
    fchk(1'b0);
    $display("test resync and deviation done");
    m.send_header(16, 8, 8'h55, 8'h3c);
    fchk(1'b1);
    clr;
    // First synch interval 25 cycles against 32 expected
    m.send_break(16, 16);
    m.hold(1'b0, 12);
    m.hold(1'b1, 13);
    m.hold(1'b0, 16);
    m.hold(1'b1, 64);
    fchk(1'b1);
    clr;
    wr(3'h4, 8'h0f);
    m.send_header(17, 17, 8'h55, 8'h3c);
    rchk(3'h3, 8'h11);
    rchk(3'h4, 8'h07);
    clr;
    wr(3'h4, 8'h0f);
    m.send_char(8'ha5, 17);
    m.hold(1'b1, 34);
    rchk(3'h3, 8'h10);
    clr;
    $display("test update method done");
    wr(3'h4, 8'h03);
    m.send_header(16, 16, 8'h15, 8'h3c);
    fchk(1'b1);
    clr;
    m.send_break(16, 16);
    repeat (960) @(posedge ref_clk);
    fchk(1'b1);
    $display("test header errors done");
    end_sim;
  end
endmodule
